// ### hw/snooze_host_pkg.sv
/*
  Constants, types and device register map for the host-side sequencer that
  arms the device's low-power wake-up reception on its receive channel.
  Assumes the device answers each register request with a one-cycle ack.
*/
package snooze_host_pkg;

  // ------------------------------------------------------------------
  // device register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] STANDBY_CONTROL_REG_ADDR      = 8'h00;
  localparam logic [7:0] FLAG_CLEAR_TRIGGER_REG_ADDR   = 8'h04;
  localparam logic [7:0] CHANNEL_DATA_DIVISOR_REG_ADDR = 8'h08;
  localparam logic [7:0] PRESCALER_SELECT_REG_ADDR     = 8'h0c;
  localparam logic [7:0] CHANNEL_MODE_REG_ADDR         = 8'h10;
  localparam logic [7:0] UNIT_STOP_REG_ADDR            = 8'h14;
  localparam logic [7:0] CHANNEL_START_REG_ADDR        = 8'h18;
  localparam logic [7:0] TRANSFER_ACTIVE_REG_ADDR      = 8'h1c;

  // ------------------------------------------------------------------
  // field positions and values
  // ------------------------------------------------------------------
  localparam int unsigned WAKE_EN_BIT       = 1;
  localparam int unsigned SUPPRESS_BIT      = 0;
  localparam int unsigned MODE_CHOICE_BIT   = 15;
  localparam int unsigned MODE_ERR_EN_BIT   = 0;
  localparam int unsigned DIV_LSB           = 9;
  localparam int unsigned PRS_HIGH_LSB      = 4;
  localparam logic [15:0] MODE_UART_RX      = 16'h0002;
  localparam logic [15:0] ALL_ERR_FLAGS     = 16'h0007;
  localparam logic [15:0] ALL_CHANNELS      = 16'h000f;
  localparam logic [15:0] RX_CHANNEL_MASK   = 16'h0002;
  localparam logic [3:0]  ACTIVE_MASK       = 4'hf;
  localparam logic [6:0]  DIV_MIN           = 7'h02;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] prs_low;
    logic [3:0] prs_high;
    logic       choice;
    logic [6:0] divisor;
  } baud_cfg_t;

  typedef struct packed {
    baud_cfg_t wake_baud;
    baud_cfg_t norm_baud;
    logic      err_en;
    logic      suppress;
    logic      nine_bit;
  } job_cfg_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } reg_rsp_t;

  typedef enum logic [4:0] {
    ST_IDLE     = 5'h00,
    ST_POLL     = 5'h01,
    ST_STOP_ALL = 5'h03,
    ST_SNZ_PRS  = 5'h02,
    ST_SNZ_MODE = 5'h06,
    ST_SNZ_DIV  = 5'h07,
    ST_CLR_FLG  = 5'h05,
    ST_FLUSH    = 5'h04,
    ST_ARM      = 5'h0c,
    ST_START    = 5'h0d,
    ST_WAIT     = 5'h0f,
    ST_READ     = 5'h0e,
    ST_STOP_CH  = 5'h0a,
    ST_CLR_ERR  = 5'h0b,
    ST_DISARM   = 5'h09,
    ST_NRM_PRS  = 5'h08,
    ST_NRM_MODE = 5'h18,
    ST_NRM_DIV  = 5'h19,
    ST_RESTART  = 5'h1b,
    ST_DONE     = 5'h1a
  } state_t;

endpackage : snooze_host_pkg

// ### hw/snooze_host.sv
/*
  Host-side sequencer: prepares the device for wake-up reception on its
  receive channel, waits for the end or error interrupt, collects the
  character (8 or 9 bits) and restores normal reception.
  Assumes a device register port with request held until a one-cycle ack,
  read data valid with ack, and interrupt levels synchronous to clock_i.
*/
`timescale 1ns/10ps
module snooze_host (
  input  wire logic                      clock_i,
  input  wire logic                      srst_i,
  input  wire logic                      start_i,
  input  wire snooze_host_pkg::job_cfg_t cfg_i,
  input  wire logic                      fast_osc_sel_i,
  output logic                           busy_o,
  output logic                           done_o,
  output logic                           cfg_error_o,
  output logic                           rx_error_o,
  output logic [8:0]                     rx_data_o,
  output snooze_host_pkg::reg_req_t      reg_req_o,
  input  wire snooze_host_pkg::reg_rsp_t reg_rsp_i,
  input  wire logic                      rx_end_irq_i,
  input  wire logic                      rx_error_irq_i
);

  // ------------------------------------------------------------------
  // state and registers
  // ------------------------------------------------------------------
  snooze_host_pkg::state_t    state_q;
  snooze_host_pkg::state_t    state_d;
  snooze_host_pkg::job_cfg_t  cfg_q;
  snooze_host_pkg::reg_req_t  req_q;
  snooze_host_pkg::reg_req_t  req_d;
  logic                       err_q;
  logic [8:0]                 data_q;
  logic                       cfg_err_q;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  wire logic acked      = req_q.valid & reg_rsp_i.ack;
  wire logic any_active = |(reg_rsp_i.rdata[3:0] & snooze_host_pkg::ACTIVE_MASK);
  wire logic div_bad_w  = cfg_i.wake_baud.divisor < snooze_host_pkg::DIV_MIN;
  wire logic div_bad_n  = cfg_i.norm_baud.divisor < snooze_host_pkg::DIV_MIN;
  wire logic cfg_bad    = div_bad_w | div_bad_n | ~fast_osc_sel_i;
  wire logic take_job   = start_i & (state_q == snooze_host_pkg::ST_IDLE);
  wire logic irq_seen   = rx_end_irq_i | rx_error_irq_i;
  wire logic [8:0] rx_pick = cfg_q.nine_bit ? reg_rsp_i.rdata[8:0]
                                            : {1'b0, reg_rsp_i.rdata[7:0]};

  // prescaler register image, both fields written, device picks one
  function automatic logic [15:0] prs_word(input snooze_host_pkg::baud_cfg_t b);
    logic [15:0] w;
    w = 16'h0000;
    w[3:0] = b.prs_low;
    w[snooze_host_pkg::PRS_HIGH_LSB +: 4] = b.prs_high;
    return w;
  endfunction : prs_word

  // mode register image with prescaler choice and error enable
  function automatic logic [15:0] mode_word(input snooze_host_pkg::baud_cfg_t b,
                                            input logic                      err_en);
    logic [15:0] w;
    w = snooze_host_pkg::MODE_UART_RX;
    w[snooze_host_pkg::MODE_CHOICE_BIT] = b.choice;
    w[snooze_host_pkg::MODE_ERR_EN_BIT] = err_en;
    return w;
  endfunction : mode_word

  // divisor image in bits 15:9 of the data register
  function automatic logic [15:0] div_word(input snooze_host_pkg::baud_cfg_t b);
    logic [15:0] w;
    w = 16'h0000;
    w[snooze_host_pkg::DIV_LSB +: 7] = b.divisor;
    return w;
  endfunction : div_word

  // ------------------------------------------------------------------
  // request for the access belonging to a state
  // ------------------------------------------------------------------
  function automatic snooze_host_pkg::reg_req_t op_of(input snooze_host_pkg::state_t  s,
                                                      input snooze_host_pkg::job_cfg_t c);
    snooze_host_pkg::reg_req_t r;
    logic [15:0]               w;
    r = '0;
    w = 16'h0000;
    r.valid = 1'b1;
    r.write = 1'b1;
    case (s)
      snooze_host_pkg::ST_POLL:
      begin
        r.write = 1'b0;
        r.addr  = snooze_host_pkg::TRANSFER_ACTIVE_REG_ADDR;
      end
      snooze_host_pkg::ST_STOP_ALL:
      begin
        r.addr  = snooze_host_pkg::UNIT_STOP_REG_ADDR;
        r.wdata = snooze_host_pkg::ALL_CHANNELS;
      end
      snooze_host_pkg::ST_SNZ_PRS:
      begin
        r.addr  = snooze_host_pkg::PRESCALER_SELECT_REG_ADDR;
        r.wdata = prs_word(c.wake_baud);
      end
      snooze_host_pkg::ST_SNZ_MODE:
      begin
        r.addr  = snooze_host_pkg::CHANNEL_MODE_REG_ADDR;
        r.wdata = mode_word(c.wake_baud, c.err_en);
      end
      snooze_host_pkg::ST_SNZ_DIV:
      begin
        r.addr  = snooze_host_pkg::CHANNEL_DATA_DIVISOR_REG_ADDR;
        r.wdata = div_word(c.wake_baud);
      end
      snooze_host_pkg::ST_CLR_FLG, snooze_host_pkg::ST_CLR_ERR:
      begin
        r.addr  = snooze_host_pkg::FLAG_CLEAR_TRIGGER_REG_ADDR;
        r.wdata = snooze_host_pkg::ALL_ERR_FLAGS;
      end
      snooze_host_pkg::ST_FLUSH, snooze_host_pkg::ST_READ:
      begin
        r.write = 1'b0;
        r.addr  = snooze_host_pkg::CHANNEL_DATA_DIVISOR_REG_ADDR;
      end
      snooze_host_pkg::ST_ARM:
      begin
        w[snooze_host_pkg::WAKE_EN_BIT]  = 1'b1;
        w[snooze_host_pkg::SUPPRESS_BIT] = c.suppress;
        r.addr  = snooze_host_pkg::STANDBY_CONTROL_REG_ADDR;
        r.wdata = w;
      end
      snooze_host_pkg::ST_START, snooze_host_pkg::ST_RESTART:
      begin
        r.addr  = snooze_host_pkg::CHANNEL_START_REG_ADDR;
        r.wdata = snooze_host_pkg::RX_CHANNEL_MASK;
      end
      snooze_host_pkg::ST_STOP_CH:
      begin
        r.addr  = snooze_host_pkg::UNIT_STOP_REG_ADDR;
        r.wdata = snooze_host_pkg::RX_CHANNEL_MASK;
      end
      snooze_host_pkg::ST_DISARM:
      begin
        r.addr  = snooze_host_pkg::STANDBY_CONTROL_REG_ADDR;
        r.wdata = 16'h0000;
      end
      snooze_host_pkg::ST_NRM_PRS:
      begin
        r.addr  = snooze_host_pkg::PRESCALER_SELECT_REG_ADDR;
        r.wdata = prs_word(c.norm_baud);
      end
      snooze_host_pkg::ST_NRM_MODE:
      begin
        r.addr  = snooze_host_pkg::CHANNEL_MODE_REG_ADDR;
        r.wdata = mode_word(c.norm_baud, c.err_en);
      end
      snooze_host_pkg::ST_NRM_DIV:
      begin
        r.addr  = snooze_host_pkg::CHANNEL_DATA_DIVISOR_REG_ADDR;
        r.wdata = div_word(c.norm_baud);
      end
      default:
      begin
        r = '0;
      end
    endcase
    return r;
  endfunction : op_of

  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  // next state: each access state advances on its ack; ST_POLL also needs no channel active
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      snooze_host_pkg::ST_IDLE:
      begin
        if (start_i && !cfg_bad)
          state_d = snooze_host_pkg::ST_POLL;
      end
      snooze_host_pkg::ST_POLL:
      begin
        if (acked && !any_active)
          state_d = snooze_host_pkg::ST_STOP_ALL;
      end
      snooze_host_pkg::ST_STOP_ALL:
      begin
        if (acked)
          state_d = snooze_host_pkg::ST_SNZ_PRS;
      end
      snooze_host_pkg::ST_SNZ_PRS:
      begin
        if (acked)
          state_d = snooze_host_pkg::ST_SNZ_MODE;
      end
      snooze_host_pkg::ST_SNZ_MODE:
      begin
        if (acked)
          state_d = snooze_host_pkg::ST_SNZ_DIV;
      end
      snooze_host_pkg::ST_SNZ_DIV:
      begin
        if (acked)
          state_d = cfg_q.suppress ? snooze_host_pkg::ST_CLR_FLG : snooze_host_pkg::ST_ARM;
      end
      snooze_host_pkg::ST_CLR_FLG:
      begin
        if (acked)
          state_d = snooze_host_pkg::ST_FLUSH;
      end
      snooze_host_pkg::ST_FLUSH:
      begin
        if (acked)
          state_d = snooze_host_pkg::ST_ARM;
      end
      snooze_host_pkg::ST_ARM:
      begin
        if (acked)
          state_d = snooze_host_pkg::ST_START;
      end
      snooze_host_pkg::ST_START:
      begin
        if (acked)
          state_d = snooze_host_pkg::ST_WAIT;
      end
      snooze_host_pkg::ST_WAIT:
      begin
        // suppressed errors give no interrupt, so keep waiting
        if (irq_seen)
          state_d = snooze_host_pkg::ST_READ;
      end
      snooze_host_pkg::ST_READ:
      begin
        if (acked)
          state_d = snooze_host_pkg::ST_STOP_CH;
      end
      snooze_host_pkg::ST_STOP_CH:
      begin
        if (acked)
          state_d = err_q ? snooze_host_pkg::ST_CLR_ERR : snooze_host_pkg::ST_DISARM;
      end
      snooze_host_pkg::ST_CLR_ERR:
      begin
        if (acked)
          state_d = snooze_host_pkg::ST_DISARM;
      end
      snooze_host_pkg::ST_DISARM:
      begin
        if (acked)
          state_d = snooze_host_pkg::ST_NRM_PRS;
      end
      snooze_host_pkg::ST_NRM_PRS:
      begin
        if (acked)
          state_d = snooze_host_pkg::ST_NRM_MODE;
      end
      snooze_host_pkg::ST_NRM_MODE:
      begin
        if (acked)
          state_d = snooze_host_pkg::ST_NRM_DIV;
      end
      snooze_host_pkg::ST_NRM_DIV:
      begin
        if (acked)
          state_d = snooze_host_pkg::ST_RESTART;
      end
      snooze_host_pkg::ST_RESTART:
      begin
        if (acked)
          state_d = snooze_host_pkg::ST_DONE;
      end
      snooze_host_pkg::ST_DONE:
      begin
        state_d = snooze_host_pkg::ST_IDLE;
      end
      default:
      begin
        state_d = snooze_host_pkg::ST_IDLE;
      end
    endcase
  end

  // request for the coming state, registered so the port is glitch free
  always_comb
  begin
    req_d = op_of(state_d, take_job ? cfg_i : cfg_q);
  end

  // state, request and job configuration
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      state_q <= snooze_host_pkg::ST_IDLE;
      req_q   <= '0;
      cfg_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      req_q   <= req_d;
      if (take_job)
        cfg_q <= cfg_i;
    end
  end

  // result capture: error cause and received character
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      err_q     <= 1'b0;
      data_q    <= 9'h000;
      cfg_err_q <= 1'b0;
    end
    else
    begin
      cfg_err_q <= take_job & cfg_bad;
      if (take_job)
        err_q <= 1'b0;
      else if (state_q == snooze_host_pkg::ST_WAIT && irq_seen)
        err_q <= rx_error_irq_i;
      if (state_q == snooze_host_pkg::ST_READ && acked)
        data_q <= rx_pick;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign reg_req_o   = req_q;
  assign busy_o      = state_q != snooze_host_pkg::ST_IDLE;
  assign done_o      = state_q == snooze_host_pkg::ST_DONE;
  assign cfg_error_o = cfg_err_q;
  assign rx_error_o  = err_q;
  assign rx_data_o   = data_q;

endmodule : snooze_host

// ### sim/snooze_host_asserts.sv
/*
  Port checks for the wake-up reception host sequencer, bound onto it.
  Assumes one clock domain with synchronous active-high reset.
*/
`timescale 1ns/10ps
module snooze_host_asserts (
  input wire logic                      clock_i,
  input wire logic                      srst_i,
  input wire logic                      start_i,
  input wire snooze_host_pkg::job_cfg_t cfg_i,
  input wire logic                      fast_osc_sel_i,
  input wire logic                      busy_o,
  input wire logic                      done_o,
  input wire logic                      cfg_error_o,
  input wire logic                      rx_error_o,
  input wire logic [8:0]                rx_data_o,
  input wire snooze_host_pkg::reg_req_t reg_req_o,
  input wire snooze_host_pkg::reg_rsp_t reg_rsp_i,
  input wire logic                      rx_end_irq_i,
  input wire logic                      rx_error_irq_i
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // --------------------------------------------------
  // helper terms and steps
  // --------------------------------------------------
  wire logic        ok_cfg = fast_osc_sel_i && cfg_i.wake_baud.divisor > 7'h01
                             && cfg_i.norm_baud.divisor > 7'h01;
  wire logic        wr     = reg_req_o.valid && reg_req_o.write;
  wire logic [7:0]  ad     = reg_req_o.addr;
  wire logic [15:0] wd     = reg_req_o.wdata;
  wire logic        rd_dat = reg_req_o.valid && !reg_req_o.write && ad == 8'h08;
  sequence s_take;
    start_i && !busy_o && ok_cfg;
  endsequence
  sequence s_rd(logic [7:0] a);
    reg_req_o.valid && !reg_req_o.write && ad == a;
  endsequence
  // --------------------------------------------------
  // properties
  // --------------------------------------------------
  property p_refuse;
    start_i && !busy_o && !ok_cfg |=> cfg_error_o && !busy_o && !reg_req_o.valid;
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused start misbehaved");
  property p_poll;
    s_take |=> s_rd(8'h1c) ##0 busy_o && !rx_error_o;
  endproperty
  a_poll: assert property (p_poll) else $error("job did not open with idle poll");
  property p_hold;
    reg_req_o.valid && !reg_rsp_i.ack |=> $stable(reg_req_o);
  endproperty
  a_hold: assert property (p_hold) else $error("request changed before ack");
  property p_stop;
    wr && ad == 8'h14 |-> wd == 16'h000f || wd == 16'h0002;
  endproperty
  a_stop: assert property (p_stop) else $error("bad stop word");
  property p_clr;
    wr && ad == 8'h04 |-> wd == 16'h0007;
  endproperty
  a_clr: assert property (p_clr) else $error("bad flag clear word");
  property p_mode;
    wr && ad == 8'h10 |-> wd[14:1] == 14'h0001;
  endproperty
  a_mode: assert property (p_mode) else $error("mode word not receive channel");
  property p_go;
    wr && ad == 8'h18 |-> wd == 16'h0002;
  endproperty
  a_go: assert property (p_go) else $error("bad start word");
  property p_irq;
    busy_o && !reg_req_o.valid && !done_o && (rx_end_irq_i || rx_error_irq_i)
      |=> s_rd(8'h08);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not followed by data read");
  property p_done;
    done_o |=> !done_o && !busy_o;
  endproperty
  a_done: assert property (p_done) else $error("done not a single pulse");
  property p_flush;
    $rose(wr) && ad == 8'h00 && wd[0] |-> $past(rd_dat);
  endproperty
  a_flush: assert property (p_flush) else $error("suppressed arming without data flush");
endmodule : snooze_host_asserts

bind snooze_host snooze_host_asserts snooze_host_asserts_inst (
  .clock_i(clock_i), .srst_i(srst_i), .start_i(start_i), .cfg_i(cfg_i),
  .fast_osc_sel_i(fast_osc_sel_i), .busy_o(busy_o), .done_o(done_o),
  .cfg_error_o(cfg_error_o), .rx_error_o(rx_error_o), .rx_data_o(rx_data_o),
  .reg_req_o(reg_req_o), .reg_rsp_i(reg_rsp_i), .rx_end_irq_i(rx_end_irq_i),
  .rx_error_irq_i(rx_error_irq_i)
);

// ### sim/dev_model.sv
/*
  Behavioural model of the device: registers, acks, one wake-up frame.
  Assumes the host holds each request until the one-cycle ack.
*/
`timescale 1ns/10ps
module dev_model (
  input  wire logic                      clock_i,
  input  wire logic                      srst_i,
  input  wire snooze_host_pkg::reg_req_t req_i,
  output snooze_host_pkg::reg_rsp_t      rsp_o,
  output logic                           end_irq_o,
  output logic                           err_irq_o,
  input  wire logic                      slow_i,
  input  wire logic                      err_i,
  input  wire logic [8:0]                char_i
);
  logic [1:0]  standby_q;
  logic [2:0]  flags_q;
  logic [15:0] div_q, prs_q, mode_q;
  logic [3:0]  enabled_q, polls_q;
  logic [8:0]  data_q;
  logic [6:0]  wake_q;
  logic [2:0]  wait_q;
  logic [27:0] frame_q;
  logic        retry_q;
  // operation clock and frame length from the baud fields
  wire logic [3:0]  k    = mode_q[15] ? prs_q[7:4] : prs_q[3:0];
  wire logic [27:0] flen = (28'h1 << k) * (28'(div_q[15:9]) + 28'h1) * 28'h14;
  wire logic        hit  = req_i.valid && !rsp_o.ack && wait_q == (slow_i ? 3'h3 : 3'h0);
  wire logic        wr   = hit && req_i.write;
  wire logic [7:0]  a    = req_i.addr;
  // register file, ack timing and frame reception
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      {standby_q, flags_q, div_q, prs_q, mode_q, enabled_q, data_q, wake_q} <= '0;
      {rsp_o, end_irq_o, err_irq_o, wait_q, frame_q, retry_q} <= '0;
      polls_q <= 4'h2;
    end
    else
    begin
      rsp_o.ack <= hit;
      rsp_o.rdata <= ~rsp_o.rdata; // released bus shows no stale value
      wait_q <= (req_i.valid && !hit && !rsp_o.ack) ? wait_q + 3'h1 : 3'h0;
      end_irq_o <= 1'b0;
      err_irq_o <= 1'b0;
      if (hit && !req_i.write)
        rsp_o.rdata <= (a == 8'h1c) ? {12'h0, polls_q[1:0] != 2'h0, 3'h0}
                                    : {div_q[15:9], standby_q[1] ? data_q : ~data_q};
      if (hit && !req_i.write && a == 8'h1c && polls_q != 4'h0)
        polls_q <= polls_q - 4'h1;
      if (wr && a == 8'h00)
        standby_q <= req_i.wdata[1:0];
      if (wr && a == 8'h04)
        flags_q <= flags_q & ~req_i.wdata[2:0];
      if (wr && a == 8'h08)
        div_q <= req_i.wdata;
      if (wr && a == 8'h0c)
        prs_q <= req_i.wdata;
      if (wr && a == 8'h10)
        mode_q <= req_i.wdata;
      if (wr && a == 8'h14)
        enabled_q <= enabled_q & ~req_i.wdata[3:0];
      if (wr && a == 8'h18)
        enabled_q <= enabled_q | req_i.wdata[3:0];
      if (wr && a == 8'h18 && req_i.wdata[1] && standby_q[1])
      begin
        frame_q <= flen;
        retry_q <= 1'b0;
        wake_q <= div_q[15:9];
      end
      if (frame_q > 28'h1)
        frame_q <= frame_q - 28'h1;
      if (frame_q == 28'h1 && err_i && !retry_q && standby_q[0])
      begin
        frame_q <= flen;
        retry_q <= 1'b1;
      end
      else if (frame_q == 28'h1)
      begin
        frame_q <= 28'h0;
        data_q <= char_i;
        if (err_i && !retry_q)
          flags_q <= 3'h7;
        if (err_i && !retry_q && mode_q[0])
          err_irq_o <= 1'b1;
        else
          end_irq_o <= 1'b1;
      end
    end
  end
endmodule : dev_model

// ### sim/snooze_host_tb_top.sv
/*
  Self-checking bench: host sequencer against the device model.
  Assumes the bound checker and the model file are compiled first.
*/
`timescale 1ns/10ps
module snooze_host_tb_top;
  logic                      clock_i = 1'b0;
  logic                      srst_i  = 1'b1;
  logic                      start_i = 1'b0;
  logic                      fast    = 1'b1;
  logic                      slow    = 1'b0;
  logic                      err     = 1'b0;
  logic [8:0]                chr     = 9'h0;
  snooze_host_pkg::job_cfg_t cfg     = '0;
  snooze_host_pkg::reg_req_t req;
  snooze_host_pkg::reg_rsp_t rsp;
  logic                      busy, done, cfg_err, rx_err, end_irq, err_irq;
  logic [8:0]                rx_data;
  logic [3:0]                tbl [4] = '{4'b0000, 4'b1010, 4'b0011, 4'b1111};
  int                        bad_count = 0;
  int                        num_checks = 0;
  always #4 clock_i = ~clock_i;
  snooze_host snooze_host_inst (.clock_i(clock_i), .srst_i(srst_i), .start_i(start_i),
    .cfg_i(cfg), .fast_osc_sel_i(fast), .busy_o(busy), .done_o(done),
    .cfg_error_o(cfg_err), .rx_error_o(rx_err), .rx_data_o(rx_data), .reg_req_o(req),
    .reg_rsp_i(rsp), .rx_end_irq_i(end_irq), .rx_error_irq_i(err_irq));
  dev_model dev_model_inst (.clock_i(clock_i), .srst_i(srst_i), .req_i(req), .rsp_o(rsp),
    .end_irq_o(end_irq), .err_irq_o(err_irq), .slow_i(slow), .err_i(err), .char_i(chr));
  // --------------------------------------------------
  // tasks
  // --------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  // one start pulse, taken at the second edge
  task automatic kick();
    @(posedge clock_i);
    #1 start_i = 1'b1;
    @(posedge clock_i);
    #1 start_i = 1'b0;
  endtask : kick
  task automatic job(input int i);
    int n;
    n = 0;
    {cfg.err_en, cfg.suppress, err, cfg.nine_bit} = tbl[i];
    cfg.wake_baud = '{4'h1, 4'h2, i[0], 7'(2 + i)};
    slow = i[0];
    chr = 9'h1a5 + 9'(i);
    kick();
    while (done !== 1'b1 && n < 4000)
    begin
      @(posedge clock_i);
      #1 n++;
    end
    chk({15'h0, done}, 16'h1);
    chk({7'h0, rx_data}, {7'h0, cfg.nine_bit & chr[8], chr[7:0]});
    chk({15'h0, rx_err}, {15'h0, tbl[i][3] & ~tbl[i][2] & tbl[i][1]});
    chk({13'h0, dev_model_inst.flags_q}, (tbl[i] == 4'b0011) ? 16'h7 : 16'h0);
    chk({14'h0, dev_model_inst.standby_q}, 16'h0);
    chk({12'h0, dev_model_inst.enabled_q}, 16'h2);
    chk({9'h0, dev_model_inst.wake_q}, {9'h0, cfg.wake_baud.divisor});
    chk(dev_model_inst.div_q, 16'h0a00);
    chk(dev_model_inst.prs_q, 16'h0003);
    chk(dev_model_inst.mode_q, {15'h1, tbl[i][3]});
  endtask : job
  // --------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clock_i);
    #1 srst_i = 1'b0;
    cfg.norm_baud = '{4'h3, 4'h0, 1'b0, 7'h05};
    for (int r = 0; r < 2; r++)
    begin
      cfg.wake_baud.divisor = 7'(1 + r);
      fast = r[0] ? 1'b0 : 1'b1;
      kick();
      chk({14'h0, cfg_err, req.valid}, 16'h2);
    end
    fast = 1'b1;
    for (int i = 0; i < 4; i++)
      job(i);
    wrap_up();
  end
  // four jobs of a few thousand cycles at most
  initial
  begin
    repeat (30000) @(posedge clock_i);
    bad_count++;
    wrap_up();
  end
endmodule : snooze_host_tb_top
